// [hdl/async_capable_timer_counter.sv]
// Timer counter with synchronous, asynchronous and gated modes behind an Avalon-MM slave
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "timer_defines.svh"

// What this block does
// - In asynchronous external mode the count holds its value for 5 external pulses after waking from sleep.
// - In asynchronous external mode the first external pulse is dropped, so the count lags by one.
// - In asynchronous mode a period of one never wraps and the count runs on; software must use a period above one.
// - Gated mode with a non-zero prescaler misbehaves: the gate is ignored and the timer counts freely.
// - The write-block control bit has no effect and the write-pending status bit always reads zero.
module async_capable_timer_counter
    import timer_pkg::*;
#(
    parameter int CNT_W = 16
)(
    input  wire logic        sys_clk_i,         // Bus clock, 40 MHz
    input  wire logic        reset_n_i,         // Async reset, active low
    input  wire logic [3:0]  avs_address_i,     // Byte address
    input  wire logic        avs_read_i,        // Read request
    input  wire logic        avs_write_i,       // Write request
    input  wire logic [31:0] avs_writedata_i,   // Write data
    input  wire logic [3:0]  avs_byteenable_i,  // Byte lanes
    output logic      [31:0] avs_readdata_o,    // Read data
    output logic             avs_waitrequest_o, // Stall
    input  wire logic        ext_count_i,       // External count input
    input  wire logic        gate_i,            // Accumulation gate
    input  wire logic        sleep_i,           // Device in sleep
    output logic             period_match_o     // Match pulse
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Byte-lane merge of write data into a 32-bit old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
        return r;
    endfunction

    // Prescaler last count for a select code
    function automatic logic [7:0] pre_last(input logic [1:0] sel);
        unique case (sel)
            2'h0: return `PRE_LAST_0;
            2'h1: return `PRE_LAST_1;
            2'h2: return `PRE_LAST_2;
            2'h3: return `PRE_LAST_3;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    control_type        ctrl_r;
    logic [CNT_W-1:0]   count_r;
    logic [CNT_W-1:0]   period_r;
    logic               flag_r;
    logic [7:0]         pre_r;
    logic               ext_prev_r;
    logic               drop_first_r;
    logic [2:0]         hold_cnt_r;
    logic [2:0]         gap_r;
    wake_state_type     state_r;
    wake_state_type     state_nxt;
    logic               waitreq_r;
    logic [31:0]        rdata_r;
    logic               match_r;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire        sel_ctrl   = avs_address_i == `OFS_CONTROL;
    wire        sel_count  = avs_address_i == `OFS_COUNT;
    wire        sel_period = avs_address_i == `OFS_PERIOD;
    wire        sel_status = avs_address_i == `OFS_STATUS;
    wire        count_stall = avs_write_i & sel_count & (gap_r != 3'h0);
    wire        ack_nxt    = (avs_read_i | avs_write_i) & waitreq_r & ~count_stall;
    wire        wr_done    = avs_write_i & ~waitreq_r;
    wire        wr_ctrl    = wr_done & sel_ctrl;
    wire        wr_count   = wr_done & sel_count;
    wire        wr_period  = wr_done & sel_period;
    wire        wr_status  = wr_done & sel_status;
    wire [31:0] ctrl_word  = {16'h0000, ctrl_r};
    wire [31:0] ctrl_wr    = merge(ctrl_word, avs_writedata_i, avs_byteenable_i) & {16'h0000, `CTRL_WMASK};
    wire [31:0] count_wr   = merge({{(32-CNT_W){1'b0}}, count_r}, avs_writedata_i, avs_byteenable_i);
    wire [31:0] period_wr  = merge({{(32-CNT_W){1'b0}}, period_r}, avs_writedata_i, avs_byteenable_i);
    wire        flag_clr   = wr_status & avs_byteenable_i[0] & avs_writedata_i[`BIT_MATCH_FLAG];

    // Read mux, unmapped reads zero
    wire [31:0] rd_mux = sel_ctrl   ? ctrl_word :
                         sel_count  ? {{(32-CNT_W){1'b0}}, count_r} :
                         sel_period ? {{(32-CNT_W){1'b0}}, period_r} :
                         sel_status ? {31'h0, flag_r} : 32'h0;

    // ------------------------------------------------------------------------
    // Count source selection
    // ------------------------------------------------------------------------
    wire ext_edge   = ext_count_i & ~ext_prev_r;
    wire async_mode = ctrl_r.clock_source_select & ~ctrl_r.external_sync_select &
                      (ctrl_r.external_clock_select == `ECS_ASYNC);
    wire gate_bug   = ctrl_r.gate_accumulate_enable & (ctrl_r.prescale_select != 2'h0);
    wire gate_open  = ~ctrl_r.gate_accumulate_enable | gate_i | gate_bug;
    wire src_tick   = ctrl_r.clock_source_select ? ext_edge : gate_open;
    wire awake_ok   = (state_r == ST_RUN) | ((state_r == ST_SLEEP) & async_mode);
    wire drop_now   = async_mode & drop_first_r & ext_edge;
    wire raw_tick   = ctrl_r.enable & awake_ok & src_tick & ~drop_now;
    wire cnt_tick   = raw_tick & (pre_r == pre_last(ctrl_r.prescale_select));
    wire no_wrap    = async_mode & (period_r == CNT_W'(1));
    wire at_match   = (count_r == period_r) & ~no_wrap;
    wire hold_done  = ext_edge & (hold_cnt_r == `WAKE_HOLD_PULSES - 3'h1);

    // Sleep and wake sequencing
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RUN:   if (sleep_i) state_nxt = ST_SLEEP;
            ST_SLEEP: if (!sleep_i) state_nxt = async_mode ? ST_HOLD : ST_RUN;
            ST_HOLD:  if (hold_done || !async_mode) state_nxt = ST_RUN;
            default:  state_nxt = ST_RUN;
        endcase
    end

    // ------------------------------------------------------------------------
    // Bus slave registers
    // ------------------------------------------------------------------------
    // Handshake and read data
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            waitreq_r <= 1'b1;
            rdata_r   <= 32'h0;
        end
        else
        begin
            waitreq_r <= ~ack_nxt;
            if (ack_nxt) rdata_r <= rd_mux;
        end
    end

    // Control and period
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctrl_r   <= `CTRL_RESET;
            period_r <= CNT_W'(`PERIOD_RESET);
        end
        else
        begin
            if (wr_ctrl) ctrl_r <= ctrl_wr[15:0];
            if (wr_period) period_r <= period_wr[CNT_W-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Timer core
    // ------------------------------------------------------------------------
    // Count, match flag and match pulse; set wins over clear
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count_r <= '0;
            flag_r  <= 1'b0;
            match_r <= 1'b0;
        end
        else
        begin
            match_r <= cnt_tick & at_match & ~wr_count;
            flag_r  <= (cnt_tick & at_match & ~wr_count) | (flag_r & ~flag_clr);
            if (wr_count) count_r <= count_wr[CNT_W-1:0];
            else if (cnt_tick) count_r <= at_match ? '0 : count_r + CNT_W'(1);
        end
    end

    // Prescaler, edge memory, first-pulse drop and wake hold
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pre_r        <= 8'h00;
            ext_prev_r   <= 1'b0;
            drop_first_r <= 1'b1;
            hold_cnt_r   <= 3'h0;
            gap_r        <= 3'h0;
            state_r      <= ST_RUN;
        end
        else
        begin
            ext_prev_r   <= ext_count_i;
            state_r      <= state_nxt;
            if (wr_ctrl || cnt_tick) pre_r <= 8'h00;
            else if (raw_tick) pre_r <= pre_r + 8'h01;
            if (!async_mode || !ctrl_r.enable) drop_first_r <= 1'b1;
            else if (ext_edge) drop_first_r <= 1'b0;
            if (state_r != ST_HOLD) hold_cnt_r <= 3'h0;
            else if (ext_edge) hold_cnt_r <= hold_cnt_r + 3'h1;
            if (wr_count) gap_r <= `COUNT_WRITE_GAP - 3'h1;
            else if (gap_r != 3'h0) gap_r <= gap_r - 3'h1;
        end
    end

    assign avs_readdata_o    = rdata_r;
    assign avs_waitrequest_o = waitreq_r;
    assign period_match_o    = match_r;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence ctrl_read_ack;
        avs_read_i && sel_ctrl && ack_nxt;
    endsequence
    sequence count_write_ack;
        wr_count;
    endsequence

    wake_hold_a: assert property ((state_r == ST_HOLD) && !wr_count |=> count_r == $past(count_r))
        else $error("count moved during wake hold");
    hold_exit_a: assert property ((state_r == ST_HOLD) && async_mode && hold_done |=> state_r == ST_RUN)
        else $error("wake hold not left after five pulses");
    first_drop_a: assert property (drop_now && !wr_count |=> count_r == $past(count_r))
        else $error("first async pulse was counted");
    period_one_a: assert property (cnt_tick && !wr_count && no_wrap && count_r == CNT_W'(1)
                                   |=> count_r == $past(count_r) + CNT_W'(1))
        else $error("period of one wrapped in async mode");
    gate_ignored_a: assert property (ctrl_r.enable && (state_r == ST_RUN) && !ctrl_r.clock_source_select
                                     && gate_bug && !gate_i |-> raw_tick)
        else $error("gate honoured with prescaler on");
    write_gap_a: assert property (count_write_ack |=> !wr_count [*3])
        else $error("count writes closer than four cycles");
    pending_zero_a: assert property (ctrl_read_ack |=> !avs_readdata_o[`BIT_WRITE_PENDING])
        else $error("write pending bit read as one");
    period_wrap_a: assert property (cnt_tick && at_match && !wr_count
                                    |=> count_r == '0 && flag_r && period_match_o)
        else $error("match did not clear count and set flag");

endmodule // async_capable_timer_counter

// [include/timer_defines.svh]
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CONTROL       4'h0
`define OFS_COUNT         4'h4
`define OFS_PERIOD        4'h8
`define OFS_STATUS        4'hc

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define BIT_WRITE_PENDING 11
`define BIT_MATCH_FLAG    0
`define ECS_ASYNC         2'h1
`define CTRL_WMASK        16'hb3b6
`define CTRL_RESET        16'h0000
`define PERIOD_RESET      16'hffff

// ----------------------------------------------------------------------------
// Prescale last-count values for ratios 1, 8, 64, 256
// ----------------------------------------------------------------------------
`define PRE_LAST_0        8'h00
`define PRE_LAST_1        8'h07
`define PRE_LAST_2        8'h3f
`define PRE_LAST_3        8'hff

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define WAKE_HOLD_PULSES  3'h5
`define COUNT_WRITE_GAP   3'h4

`endif

// [include/timer_pkg.sv]
// Types shared by the timer design
package timer_pkg;

    // Control register layout, most significant bit first
    typedef struct packed {
        logic       enable;
        logic [1:0] rsvd_14;
        logic       async_write_block;
        logic       async_write_pending;
        logic       rsvd_10;
        logic [1:0] external_clock_select;
        logic       gate_accumulate_enable;
        logic       rsvd_6;
        logic [1:0] prescale_select;
        logic       rsvd_3;
        logic       external_sync_select;
        logic       clock_source_select;
        logic       rsvd_0;
    } control_type;

    // Sleep sequencing, Gray coded
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SLEEP = 2'b01,
        ST_HOLD  = 2'b11
    } wake_state_type;

endpackage

// [tb/test_async_capable_timer_counter.sv]
// Self-checking bench for the timer counter
`timescale 1ns/1ps
`include "timer_defines.svh"
module test_async_capable_timer_counter
    import timer_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        rd_en;
    logic        wr_en;
    logic        ext;
    logic        gate;
    logic        slp;
    logic        wreq;
    logic        pm;
    logic [3:0]  adr;
    logic [3:0]  be;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] got;
    int          error_cnt;
    int          num_checks;
    int          cyc;
    int          acc;
    int          pm_cnt;
    int          a1;

    async_capable_timer_counter async_capable_timer_counter_i (
        .sys_clk_i(clk), .reset_n_i(rst_n), .avs_address_i(adr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat),
        .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .ext_count_i(ext), .gate_i(gate),
        .sleep_i(slp), .period_match_o(pm));

    // Clock, 25 ns period
    always #12.5 clk = ~clk;

    // Cycle count and match pulse count
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (pm === 1'b1)
            pm_cnt <= pm_cnt + 1;
    end

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check32(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic check1(input logic g, input logic e);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Holds the request until waitrequest is seen low
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        @(posedge clk);
        adr <= a;
        wdat <= d;
        be <= b;
        wr_en <= w;
        rd_en <= !w;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            error_cnt++;
            stop_test();
        end
        got = rdat;
        acc = cyc;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf);
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 4'hf);
        check32(got, e);
    endtask

    // Rising edges on the external count input
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge clk);
            ext <= 1'b1;
            repeat (2) @(posedge clk);
            ext <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rchk(`OFS_CONTROL, 32'h0);
        rchk(`OFS_COUNT, 32'h0);
        rchk(`OFS_PERIOD, 32'h0000ffff);
        rchk(`OFS_STATUS, 32'h0);
        wr(4'h2, 32'hffffffff);
        rchk(4'h2, 32'h0);
        wr(`OFS_CONTROL, 32'hffffffff);
        rchk(`OFS_CONTROL, 32'h0000b3b6);
        wr(`OFS_CONTROL, 32'h00009102);
        wr(`OFS_COUNT, 32'h00000042);
        rchk(`OFS_COUNT, 32'h00000042);
        rchk(`OFS_CONTROL, 32'h00009102);
        wr(`OFS_PERIOD, 32'h00001234);
        xfer(1'b1, `OFS_PERIOD, 32'h0000ff56, 4'h1);
        rchk(`OFS_PERIOD, 32'h00001256);
    endtask

    task automatic t_sync();
        wr(`OFS_CONTROL, 32'h0);
        wr(`OFS_PERIOD, 32'h3);
        wr(`OFS_COUNT, 32'h0);
        wr(`OFS_CONTROL, 32'h00008106);
        pulse(3);
        rchk(`OFS_COUNT, 32'h3);
        check32(pm_cnt, 32'h0);
        pulse(1);
        rchk(`OFS_COUNT, 32'h0);
        check32(pm_cnt, 32'h1);
        rchk(`OFS_STATUS, 32'h1);
        wr(`OFS_STATUS, 32'h1);
        rchk(`OFS_STATUS, 32'h0);
    endtask

    // Period of one in async mode: first edge lost, no wrap
    task automatic t_async();
        wr(`OFS_CONTROL, 32'h0);
        wr(`OFS_PERIOD, 32'h1);
        wr(`OFS_COUNT, 32'h0);
        wr(`OFS_CONTROL, 32'h00008102);
        pulse(4);
        rchk(`OFS_COUNT, 32'h3);
        check32(pm_cnt, 32'h1);
    endtask

    task automatic t_wake();
        slp <= 1'b1;
        pulse(2);
        rchk(`OFS_COUNT, 32'h5);
        slp <= 1'b0;
        pulse(5);
        rchk(`OFS_COUNT, 32'h5);
        pulse(1);
        rchk(`OFS_COUNT, 32'h6);
    endtask

    task automatic t_gate();
        wr(`OFS_PERIOD, 32'hffff);
        wr(`OFS_CONTROL, 32'h00008080);
        wr(`OFS_COUNT, 32'h0);
        repeat (20) @(posedge clk);
        rchk(`OFS_COUNT, 32'h0);
        // Gate open for ten clocks, prescale 1: ten counts
        gate <= 1'b1;
        repeat (10) @(posedge clk);
        gate <= 1'b0;
        rchk(`OFS_COUNT, 32'ha);
        // Gate closed but prescale 8: counts every eighth clock regardless
        wr(`OFS_CONTROL, 32'h00008090);
        repeat (40) @(posedge clk);
        rchk(`OFS_COUNT, 32'hf);
    endtask

    // Back-to-back count writes are stalled to four cycles
    task automatic t_space();
        wr(`OFS_CONTROL, 32'h0);
        wr(`OFS_COUNT, 32'h11);
        a1 = acc;
        wr(`OFS_COUNT, 32'h22);
        check1(acc - a1 >= 4, 1'b1);
        rchk(`OFS_COUNT, 32'h22);
    endtask

    // Reset, then the scenarios
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        adr = 4'h0;
        be = 4'hf;
        wdat = 32'h0;
        ext = 1'b0;
        gate = 1'b0;
        slp = 1'b0;
        error_cnt = 0;
        num_checks = 0;
        cyc = 0;
        pm_cnt = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_sync();
        t_async();
        t_wake();
        t_gate();
        t_space();
        stop_test();
    end
endmodule // test_async_capable_timer_counter
